// ==== hdl/seg_top.sv ====
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module seg_top (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  // Avalon-MM slave
  input wire logic [seg_pkg::AV_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Chip mode and ECC datapath status
  input wire logic I_SPECIAL_MODE,
  input wire logic I_MEM_READY,
  input wire logic I_SINGLE_ERR,
  // Memory debug port
  output logic O_DBG_REQ,
  output logic O_DBG_WE,
  output logic [seg_pkg::ADDR_W-1:0] O_DBG_ADDR,
  output logic [seg_pkg::DATA_W-1:0] O_DBG_WDATA,
  output logic [seg_pkg::ECC_W-1:0] O_DBG_WECC,
  input wire logic I_DBG_GNT,
  input wire logic I_DBG_DONE,
  input wire logic [seg_pkg::DATA_W-1:0] I_DBG_RDATA,
  input wire logic [seg_pkg::ECC_W-1:0] I_DBG_RECC,
  // Datapath control and interrupt
  output logic O_REPAIR_DISABLE,
  output logic O_IRQ
);
  import seg_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic irq_en;
    logic flag;
    logic [ADDR_W-1:0] ptr;
    logic [DATA_W-1:0] word;
    logic [ECC_W-1:0] ecc;
    logic rep_dis;
    logic cmd_wr;
    logic cmd_rd;
    seg_state_t state;
    logic irq;
  } seg_top_t;

  seg_top_t st_ff;
  seg_top_t nxt_st;
  logic special_s;
  logic ready_s;
  logic req;
  logic wr_hit;
  logic [REG_W-1:0] wb;
  logic [ECC_W-1:0] gen_ecc;

  // Mode pin and initialisation status come from outside the clock domain
  seg_sync u_sync_mode (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_d(I_SPECIAL_MODE),
    .o_q(special_s)
  );

  seg_sync u_sync_rdy (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_d(I_MEM_READY),
    .o_q(ready_s)
  );

  // Generated check bits for the staged word, visible at the status word
  seg_ecc_gen u_ecc (
    .i_data(st_ff.word),
    .o_ecc(gen_ecc)
  );

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr_hit = I_AVS_WRITE & I_AVS_BYTEENABLE[0] & ~st_ff.ack & I_CE;
  assign wb = I_AVS_WRITEDATA[REG_W-1:0];

  always_comb begin
    nxt_st = st_ff;
    if (I_CE) begin
      nxt_st.ack = req & ~st_ff.ack;
      if (req & ~st_ff.ack) begin
        // Read data stand until the next read completes; writes leave them
        if (I_AVS_READ) begin
          nxt_st.rdata = UNMAPPED_DATA;
          case (I_AVS_ADDRESS)
            OFS_STAT: begin
              nxt_st.rdata = {16'h0000, 2'b00, gen_ecc, 7'h00, ready_s};
            end
            OFS_IE: begin
              nxt_st.rdata[0] = st_ff.irq_en;
            end
            OFS_IF: begin
              nxt_st.rdata[BIT_FLAG] = st_ff.flag;
            end
            OFS_PTRH: begin
              nxt_st.rdata[REG_W-1:0] = st_ff.ptr[23:16];
            end
            OFS_PTRM: begin
              nxt_st.rdata[REG_W-1:0] = st_ff.ptr[15:8];
            end
            OFS_PTRL: begin
              nxt_st.rdata[REG_W-1:0] = st_ff.ptr[7:0];
            end
            OFS_DDH: begin
              nxt_st.rdata[REG_W-1:0] = st_ff.word[15:8];
            end
            OFS_DDL: begin
              nxt_st.rdata[REG_W-1:0] = st_ff.word[7:0];
            end
            OFS_DE: begin
              nxt_st.rdata[ECC_W-1:0] = st_ff.ecc;
            end
            OFS_CMD: begin
              nxt_st.rdata[BIT_RR] = st_ff.rep_dis;
              nxt_st.rdata[BIT_WR] = st_ff.cmd_wr;
              nxt_st.rdata[BIT_RD] = st_ff.cmd_rd;
            end
            default: begin
              nxt_st.rdata = UNMAPPED_DATA;
            end
          endcase
        end
      end

      // Event sets after the clear so a same-cycle error is kept
      if (wr_hit && I_AVS_ADDRESS == OFS_IF && wb[BIT_FLAG]) begin
        nxt_st.flag = 1'b0;
      end
      if (I_SINGLE_ERR) begin
        nxt_st.flag = 1'b1;
      end

      if (wr_hit) begin
        case (I_AVS_ADDRESS)
          OFS_IE: begin
            nxt_st.irq_en = wb[0];
          end
          OFS_PTRH: begin
            nxt_st.ptr[23:16] = wb;
          end
          OFS_PTRM: begin
            nxt_st.ptr[15:8] = wb;
          end
          OFS_PTRL: begin
            nxt_st.ptr[7:0] = wb & PTR_IMPL_MASK[7:0];
          end
          OFS_DDH: begin
            nxt_st.word[15:8] = wb;
          end
          OFS_DDL: begin
            nxt_st.word[7:0] = wb;
          end
          OFS_DE: begin
            nxt_st.ecc = wb[ECC_W-1:0];
          end
          OFS_CMD: begin
            if (special_s) begin
              nxt_st.rep_dis = wb[BIT_RR];
              if (!st_ff.cmd_wr && !st_ff.cmd_rd) begin
                if (wb[BIT_WR]) begin
                  nxt_st.cmd_wr = 1'b1;
                end else if (wb[BIT_RD]) begin
                  nxt_st.cmd_rd = 1'b1;
                end
              end
            end
          end
          default: begin
            nxt_st.irq_en = st_ff.irq_en;
          end
        endcase
      end

      case (st_ff.state)
        ST_IDLE: begin
          if (st_ff.cmd_wr || st_ff.cmd_rd) begin
            nxt_st.state = ST_REQ;
          end
        end
        ST_REQ: begin
          // Lowest priority: arbiter grants only with no system access
          if (ready_s && I_DBG_GNT) begin
            nxt_st.state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (I_DBG_DONE) begin
            nxt_st.state = ST_IDLE;
            if (st_ff.cmd_wr) begin
              nxt_st.cmd_wr = 1'b0;
            end else begin
              nxt_st.cmd_rd = 1'b0;
              nxt_st.word = I_DBG_RDATA;
              nxt_st.ecc = I_DBG_RECC;
            end
          end
        end
        default: begin
          nxt_st.state = ST_IDLE;
        end
      endcase

      nxt_st.irq = nxt_st.flag & nxt_st.irq_en;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_ff <= '{ack: 1'b0, rdata: UNMAPPED_DATA, irq_en: 1'b0, flag: 1'b0,
                 ptr: PTR_RST, word: WORD_RST, ecc: ECC_RST, rep_dis: 1'b0,
                 cmd_wr: 1'b0, cmd_rd: 1'b0, state: ST_IDLE, irq: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign O_AVS_WAITREQUEST = req & ~st_ff.ack;
  assign O_AVS_READDATA = st_ff.rdata;
  assign O_DBG_REQ = (st_ff.state == ST_REQ) & ready_s;
  assign O_DBG_WE = st_ff.cmd_wr;
  assign O_DBG_ADDR = st_ff.ptr;
  assign O_DBG_WDATA = st_ff.word;
  assign O_DBG_WECC = st_ff.ecc;
  assign O_REPAIR_DISABLE = st_ff.rep_dis;
  assign O_IRQ = st_ff.irq;
endmodule : seg_top

// ==== hdl/seg_pkg.sv ====
package seg_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int ECC_W = 6;
  localparam int REG_W = 8;
  localparam int AV_ADDR_W = 6;
  localparam logic [AV_ADDR_W-1:0] OFS_STAT = 6'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_IE = 6'h04;
  localparam logic [AV_ADDR_W-1:0] OFS_IF = 6'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_PTRH = 6'h1c;
  localparam logic [AV_ADDR_W-1:0] OFS_PTRM = 6'h20;
  localparam logic [AV_ADDR_W-1:0] OFS_PTRL = 6'h24;
  localparam logic [AV_ADDR_W-1:0] OFS_DDH = 6'h30;
  localparam logic [AV_ADDR_W-1:0] OFS_DDL = 6'h34;
  localparam logic [AV_ADDR_W-1:0] OFS_DE = 6'h38;
  localparam logic [AV_ADDR_W-1:0] OFS_CMD = 6'h3c;
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_RR = 7;
  localparam int BIT_FLAG = 0;
  localparam logic [ADDR_W-1:0] PTR_IMPL_MASK = 24'hfffffe;
  localparam logic [DATA_W-1:0] ECC_MASK [ECC_W] = '{16'h443f, 16'h13c7, 16'he1d1,
                                                       16'hee60, 16'h3e8a, 16'h993c};
  localparam logic [ADDR_W-1:0] PTR_RST = 24'h000000;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ECC_W-1:0] ECC_RST = 6'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} seg_state_t;
endpackage : seg_pkg

// ==== hdl/seg_ecc_gen.sv ====
`timescale 1ns/1ps
module seg_ecc_gen (
  input wire logic [seg_pkg::DATA_W-1:0] i_data,
  output logic [seg_pkg::ECC_W-1:0] o_ecc
);
  import seg_pkg::*;
  for (genvar g = 0; g < ECC_W; g++) begin : g_bit
    assign o_ecc[g] = ~(^(i_data & ECC_MASK[g]));
  end
endmodule : seg_ecc_gen

// ==== hdl/seg_sync.sv ====
`timescale 1ns/1ps
module seg_sync (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } seg_sync_t;
  seg_sync_t st_ff;
  seg_sync_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (i_ce) begin
      nxt_st.s1 = i_d;
      nxt_st.s2 = st_ff.s1;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_q = st_ff.s2;
endmodule : seg_sync

// ==== sim/seg_checker.sv ====
`timescale 1ns/1ps
module seg_checker (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [seg_pkg::AV_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_SINGLE_ERR,
  input wire logic O_DBG_REQ,
  input wire logic [seg_pkg::ADDR_W-1:0] O_DBG_ADDR,
  input wire logic I_DBG_GNT,
  input wire logic I_DBG_DONE,
  input wire logic O_REPAIR_DISABLE,
  input wire logic O_IRQ
);
  import seg_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  one_wait_a: assert property (I_AVS_READ && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("read not answered");
  rd_hold_a: assert property (!(I_AVS_READ && O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA))
    else $error("read data moved");
  ptr_even_a: assert property (O_DBG_REQ |-> !O_DBG_ADDR[0])
    else $error("odd debug address");
  req_hold_a: assert property (O_DBG_REQ && !I_DBG_GNT |=> O_DBG_REQ && $stable(O_DBG_ADDR))
    else $error("request dropped");
  one_gnt_a: assert property (O_DBG_REQ && I_DBG_GNT |=> !O_DBG_REQ)
    else $error("request after grant");
  done_idle_a: assert property (I_DBG_DONE |=> !O_DBG_REQ [*2])
    else $error("request after done");
  rr_cause_a: assert property ($changed(O_REPAIR_DISABLE) |->
    $past(I_AVS_WRITE && I_AVS_ADDRESS == OFS_CMD)) else $error("repair bit moved");
  irq_cause_a: assert property ($changed(O_IRQ) |-> $past(I_SINGLE_ERR || I_AVS_WRITE))
    else $error("irq moved");
  cover property (O_DBG_REQ [*3] ##1 I_DBG_GNT);
  cover property ($rose(O_IRQ));
  cover property ($rose(O_REPAIR_DISABLE));
endmodule : seg_checker
bind seg_top seg_checker u_chk (.*);

// ==== sim/seg_mem_model.sv ====
`timescale 1ns/1ps
module seg_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [seg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [seg_pkg::DATA_W-1:0] i_wdata,
  input wire logic [seg_pkg::ECC_W-1:0] i_wecc,
  output logic o_gnt,
  output logic o_done,
  output logic [seg_pkg::DATA_W-1:0] o_rdata,
  output logic [seg_pkg::ECC_W-1:0] o_recc
);
  import seg_pkg::*;
  logic [21:0] mem_ff [16];
  logic [3:0] cnt_ff;
  logic busy_ff;
  initial begin
    {o_gnt, o_done, busy_ff, cnt_ff, o_rdata, o_recc} = '0;
    foreach (mem_ff[i]) mem_ff[i] = '0;
  end
  // Read lines toggle outside done
  always @(posedge i_clk) begin
    o_gnt <= 1'b0;
    o_done <= 1'b0;
    cnt_ff <= cnt_ff + 4'h1;
    {o_rdata, o_recc} <= ~{o_rdata, o_recc};
    if (i_req && !o_gnt && !busy_ff && (!i_slow || cnt_ff[2])) begin
      o_gnt <= 1'b1;
      busy_ff <= 1'b1;
      cnt_ff <= '0;
    end
    if (busy_ff && (!i_slow || cnt_ff[2])) begin
      busy_ff <= 1'b0;
      o_done <= 1'b1;
      if (i_we) mem_ff[i_addr[4:1]] <= {i_wdata, i_wecc};
      else {o_rdata, o_recc} <= mem_ff[i_addr[4:1]];
    end
  end
endmodule : seg_mem_model

// ==== sim/test_sram_ecc_debug_and_flag_regs.sv ====
`timescale 1ns/1ps
module test_sram_ecc_debug_and_flag_regs;
  import seg_pkg::*;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, spc = 0, rdy = 0, serr = 0, slow = 0, ce = 1;
  logic [AV_ADDR_W-1:0] adr = '0;
  logic [31:0] wd = '0, rdat, got = '0;
  logic wreq, req, we, gnt, done, rrd, irq;
  logic [ADDR_W-1:0] dadr;
  logic [DATA_W-1:0] dwd, drd;
  logic [ECC_W-1:0] dwe, dre;
  logic [15:0] lf = 16'h000d;
  logic [32:0] q [$];
  logic [32:0] ent;
  int err_count = 0, checks_done = 0;
  initial forever #2.5 clk = ~clk;
  seg_top u_dut (.I_CLK(clk), .I_ARST_N(rst_n), .I_CE(ce), .I_AVS_ADDRESS(adr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'h1),
    .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_SPECIAL_MODE(spc),
    .I_MEM_READY(rdy), .I_SINGLE_ERR(serr), .O_DBG_REQ(req), .O_DBG_WE(we),
    .O_DBG_ADDR(dadr), .O_DBG_WDATA(dwd), .O_DBG_WECC(dwe), .I_DBG_GNT(gnt),
    .I_DBG_DONE(done), .I_DBG_RDATA(drd), .I_DBG_RECC(dre), .O_REPAIR_DISABLE(rrd),
    .O_IRQ(irq));
  seg_mem_model u_mem (.i_clk(clk), .i_slow(slow), .i_req(req), .i_we(we), .i_addr(dadr),
    .i_wdata(dwd), .i_wecc(dwe), .o_gnt(gnt), .o_done(done), .o_rdata(drd), .o_recc(dre));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  // Expected check bits, straight from the parity equations
  function automatic logic [5:0] ecc_of(input logic [15:0] d);
    logic [15:0] m [6];
    m = '{16'h443f, 16'h13c7, 16'he1d1, 16'hee60, 16'h3e8a, 16'h993c};
    for (int b = 0; b < 6; b++) ecc_of[b] = ~(^(d & m[b]));
  endfunction : ecc_of
  task automatic final_report();
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic fail(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) fail(m);
  endtask : chk
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    // Request stands until the rising edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    got = rdat;
    wr <= 0;
    rd <= 0;
    if (n >= 20) begin
      fail("bus hang");
      final_report();
    end
  endtask : bus
  task automatic rdx(input logic [5:0] a, input logic [31:0] e);
    q.push_back({1'b1, e});
    bus(a, 0, 8'h0);
  endtask : rdx
  task automatic poll();
    int n = 0;
    do begin
      q.push_back(33'h0);
      bus(OFS_CMD, 0, 8'h0);
      n++;
    end while (got[1:0] !== 2'b00 && n < 50);
    if (n >= 50) fail("command stuck");
  endtask : poll
  // Oldest note against each completed read
  always @(posedge clk) begin
    if (rd && wreq === 1'b0) begin
      ent = q.pop_front();
      if (ent[32]) checks_done++;
      if (ent[32] && rdat !== ent[31:0]) fail("read data");
    end
  end
  initial begin
    logic [7:0] dh, dl, de;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rdx(OFS_PTRH, 8'h00);
    rdx(6'h0c, 8'h00);
    bus(OFS_PTRL, 1, 8'hff);
    rdx(OFS_PTRL, 8'hfe);
    bus(OFS_PTRH, 1, 8'hab);
    rdx(OFS_PTRH, 8'hab);
    bus(OFS_DE, 1, 8'hff);
    rdx(OFS_DE, 8'h3f);
    bus(OFS_CMD, 1, 8'h82);
    rdx(OFS_CMD, 8'h00);
    spc <= 1;
    for (int i = 0; i < 2; i++) begin
      lf = nxt(lf);
      dh = lf[15:8];
      dl = lf[7:0];
      lf = nxt(lf);
      de = {2'b0, lf[5:0]};
      slow <= i[0];
      bus(OFS_DDH, 1, dh);
      bus(OFS_DDL, 1, dl);
      bus(OFS_DE, 1, de);
      bus(OFS_CMD, 1, 8'h03);
      rdx(OFS_CMD, 8'h02);
      if (i == 0) begin
        bus(OFS_CMD, 1, 8'h01);
        rdx(OFS_CMD, 8'h02);
        rdy <= 1;
      end
      poll();
      bus(OFS_DDL, 1, ~dl);
      bus(OFS_CMD, 1, 8'h01);
      poll();
      rdx(OFS_DDH, dh);
      rdx(OFS_DDL, dl);
      rdx(OFS_DE, de);
      rdx(OFS_STAT, {18'h0, ecc_of({dh, dl}), 7'h0, 1'b1});
    end
    bus(OFS_CMD, 1, 8'h80);
    rdx(OFS_CMD, 8'h80);
    chk(rrd === 1'b1, "repair disable");
    bus(OFS_IE, 1, 8'h01);
    rdx(OFS_IE, 8'h01);
    @(posedge clk) serr <= 1;
    @(posedge clk) serr <= 0;
    rdx(OFS_IF, 8'h01);
    chk(irq === 1'b1, "irq");
    bus(OFS_IF, 1, 8'h00);
    rdx(OFS_IF, 8'h01);
    bus(OFS_IF, 1, 8'h01);
    rdx(OFS_IF, 8'h00);
    chk(irq === 1'b0, "irq clear");
    // An error pulse while the clock enable is low must be lost
    @(posedge clk) begin
      ce <= 0;
      serr <= 1;
    end
    @(posedge clk) serr <= 0;
    @(posedge clk) ce <= 1;
    rdx(OFS_IF, 8'h00);
    // Second reset in mid-run returns registers to zero
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rdx(OFS_PTRH, 8'h00);
    rdx(OFS_CMD, 8'h00);
    chk(rrd === 1'b0, "repair after reset");
    final_report();
  end
endmodule : test_sram_ecc_debug_and_flag_regs
